//--- fcr_map.vh
// fcr_map.vh: offsets, field positions, reset values and keys of the flash register block
// assumes: included by bare name, plain verilog-2005
`ifndef FCR_MAP_VH
`define FCR_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FCR_BASE_ADDR 32'h40022000
`define FCR_OFS_ACC 8'h00
`define FCR_OFS_KEY 8'h04
`define FCR_OFS_OKEY 8'h08
`define FCR_OFS_STS 8'h0C
`define FCR_OFS_OPC 8'h10
`define FCR_OFS_ADDR 8'h14
`define FCR_OFS_GAP 8'h18
`define FCR_OFS_OBS 8'h1C
`define FCR_OFS_WRP 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define FCR_ACC_WS_HI 2
`define FCR_ACC_PFE 4
`define FCR_ACC_PFA 5
`define FCR_STS_BUSY 0
`define FCR_STS_PERR 2
`define FCR_STS_WPERR 4
`define FCR_STS_DONE 5
`define FCR_OPC_PG 0
`define FCR_OPC_PER 1
`define FCR_OPC_MER 2
`define FCR_OPC_OBP 4
`define FCR_OPC_OBE 5
`define FCR_OPC_STA 6
`define FCR_OPC_LOCK 7
`define FCR_OPC_OBWEN 9
`define FCR_OPC_ERROR_IRQ_ENABLE 10
`define FCR_OPC_DONEIE 12
`define FCR_OPC_MASK 32'h000016F7
// ----------------------------------------
// reset values, codes, keys, timing
// ----------------------------------------
`define FCR_ACC_RST 32'h00000000
`define FCR_STS_RST 32'h00000000
`define FCR_OPC_RST 32'h00000080
`define FCR_ZERO32 32'h00000000
`define FCR_WS_ZERO 3'h0
`define FCR_WS_ONE 3'h1
`define FCR_ERASED 16'hFFFF
`define FCR_KEY1 32'h45670123
`define FCR_KEY2 32'hCDEF89AB
`define FCR_OP_CYCLES 8'h20
`endif

//--- fcr_wait.v
// fcr_wait.v: read wait-state stretcher for one flash read
// assumes: ref_clk 100 mhz, reads requested as one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "fcr_map.vh"
module fcr_wait
(
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire [2:0] wait_state_count,
  input wire rd_req,
  output reg rd_ready_ff
);
  reg wait_ff;
  reg nxt_rd_ready;
  reg nxt_wait;
  // ----------------------------------------
  // stretch by one cycle on code one
  // ----------------------------------------
  always @*
  begin
    nxt_rd_ready = 1'b0;
    nxt_wait = 1'b0;
    if (wait_ff)
      nxt_rd_ready = 1'b1;
    else if (rd_req && wait_state_count == `FCR_WS_ONE) // [R1]
      nxt_wait = 1'b1;
    else if (rd_req)
      nxt_rd_ready = 1'b1; // [R1]
  end
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_ff <= 1'b0;
      rd_ready_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      wait_ff <= nxt_wait;
      rd_ready_ff <= nxt_rd_ready;
    end
  end
endmodule // fcr_wait
`default_nettype wire

//--- fcr_regs.v
// fcr_regs.v: apb register block of the embedded flash controller
// assumes: apb master on ref_clk, array status bits given as inputs
`timescale 1ns/10ps
`default_nettype none
`include "fcr_map.vh"
// Summary of operation
// [R1] wait-state field 000 gives zero wait, 001 one wait; other codes reserved
// [R2] prefetch enable bit 4 read-write; bit 5 shows prefetch actually active
// [R3] flash key register is write only, unlocks with key pair, reads zero
// [R4] option key register unlocks option programming, write only, reads zero
// [R5] busy bit 0 stays high while program or erase runs
// [R6] program error bit 2 set when target word was not erased
// [R7] protect error bit 4 set when program hits protected region
// [R8] done bit 5 set whenever program or erase finishes
// [R9] option status at 0x1C, protect register at 0x20, 0x18 unused
// [R10] lock bit 7 write-one only; locks controller and control register
// [R11] error enable bit 10 raises irq on program or protect error
// [R12] done enable bit 12 raises irq while done flag set
// [R13] error and done flags cleared by writing one, zero leaves them
// [R14] wrong key keeps lock engaged until next reset
module fcr_regs
(
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [15:0] target_old_data,
  input wire target_protected,
  input wire [31:0] option_status,
  input wire [31:0] protect_status,
  input wire flash_rd_req,
  output wire flash_rd_ready,
  output wire [31:0] target_addr,
  output wire op_pulse,
  output wire [2:0] wait_state_count,
  output wire prefetch_active,
  output wire irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [31:0] acc_ff;
  reg [31:0] opc_ff;
  reg [31:0] addr_ff;
  reg [5:0] sts_ff;
  reg [7:0] cnt_ff;
  reg key_stage_ff;
  reg unlocked_ff;
  reg okey_stage_ff;
  reg opt_unlocked_ff;
  reg key_dead_ff;
  reg okey_dead_ff;
  reg pfa_ff;
  reg op_pulse_ff;
  reg pg_pend_ff;
  reg [31:0] nxt_prdata;
  reg [5:0] nxt_sts;
  wire wr_en;
  wire rd_setup;
  wire pg_req;
  wire [7:0] ofs;
  wire busy;
  wire start_pg;
  wire start_er;
  wire start_op;
  wire pg_fault;
  wire finish;
  wire unmapped;
  assign ofs = paddr[7:0];
  assign wr_en = psel && penable && pwrite;
  // read data latched in setup so it already stands at the access edge
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign unmapped = (paddr[31:8] != `FCR_BASE_ADDR >> 8 && paddr[31:8] != 24'h000000)
    || ofs == `FCR_OFS_GAP || ofs > `FCR_OFS_WRP || ofs[1:0] != 2'h0; // [R9]
  assign pslverr = psel && penable && unmapped;
  assign busy = sts_ff[`FCR_STS_BUSY];
  assign wait_state_count = acc_ff[`FCR_ACC_WS_HI:0];
  assign prefetch_active = pfa_ff;
  assign target_addr = addr_ff;
  assign op_pulse = op_pulse_ff;
  // ----------------------------------------
  // operation starts
  // ----------------------------------------
  // address write arms a program; checked next cycle once the array shows the new word
  assign pg_req = wr_en && !unmapped && ofs == `FCR_OFS_ADDR && unlocked_ff && !busy
    && opc_ff[`FCR_OPC_PG] && !pg_pend_ff; // [R10]
  assign start_pg = pg_pend_ff;
  assign start_er = wr_en && !unmapped && ofs == `FCR_OFS_OPC && unlocked_ff && !busy
    && pwdata[`FCR_OPC_STA] && (opc_ff[`FCR_OPC_PER] || opc_ff[`FCR_OPC_MER]
    || (opc_ff[`FCR_OPC_OBE] && opt_unlocked_ff)); // [R4]
  assign pg_fault = target_protected || target_old_data != `FCR_ERASED;
  assign start_op = (start_pg && !pg_fault) || start_er;
  assign finish = busy && cnt_ff == 8'h01;
  // ----------------------------------------
  // status flags: hardware set wins over clear
  // ----------------------------------------
  always @*
  begin
    nxt_sts = sts_ff;
    if (wr_en && !unmapped && ofs == `FCR_OFS_STS)
    begin
      if (pwdata[`FCR_STS_PERR])
        nxt_sts[`FCR_STS_PERR] = 1'b0; // [R13]
      if (pwdata[`FCR_STS_WPERR])
        nxt_sts[`FCR_STS_WPERR] = 1'b0; // [R13]
      if (pwdata[`FCR_STS_DONE])
        nxt_sts[`FCR_STS_DONE] = 1'b0; // [R13]
    end
    if (start_pg && target_old_data != `FCR_ERASED)
      nxt_sts[`FCR_STS_PERR] = 1'b1; // [R6]
    if (start_pg && target_protected)
      nxt_sts[`FCR_STS_WPERR] = 1'b1; // [R7]
    if (finish)
    begin
      nxt_sts[`FCR_STS_DONE] = 1'b1; // [R8]
      nxt_sts[`FCR_STS_BUSY] = 1'b0; // [R5]
    end
    if (start_op)
      nxt_sts[`FCR_STS_BUSY] = 1'b1; // [R5]
    nxt_sts[1] = 1'b0;
    nxt_sts[3] = 1'b0;
  end
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @*
  begin
    nxt_prdata = `FCR_ZERO32;
    case (ofs)
      `FCR_OFS_ACC: nxt_prdata = {26'h0000000, pfa_ff, acc_ff[4:0]}; // [R2]
      `FCR_OFS_KEY: nxt_prdata = `FCR_ZERO32; // [R3]
      `FCR_OFS_OKEY: nxt_prdata = `FCR_ZERO32; // [R4]
      `FCR_OFS_STS: nxt_prdata = {26'h0000000, sts_ff};
      `FCR_OFS_OPC: nxt_prdata = opc_ff;
      `FCR_OFS_OBS: nxt_prdata = option_status; // [R9]
      `FCR_OFS_WRP: nxt_prdata = protect_status; // [R9]
      default: nxt_prdata = `FCR_ZERO32;
    endcase
    if (unmapped)
      nxt_prdata = `FCR_ZERO32;
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_ff <= `FCR_ACC_RST;
      opc_ff <= `FCR_OPC_RST;
      addr_ff <= `FCR_ZERO32;
      sts_ff <= 6'h00;
      cnt_ff <= 8'h00;
      key_stage_ff <= 1'b0;
      unlocked_ff <= 1'b0;
      okey_stage_ff <= 1'b0;
      opt_unlocked_ff <= 1'b0;
      key_dead_ff <= 1'b0;
      okey_dead_ff <= 1'b0;
      pfa_ff <= 1'b0;
      op_pulse_ff <= 1'b0;
      pg_pend_ff <= 1'b0;
      prdata <= `FCR_ZERO32;
    end
    else if (clk_en)
    begin
      sts_ff <= nxt_sts;
      op_pulse_ff <= start_op;
      pg_pend_ff <= pg_req;
      // status mirrors enable only when no array access is in flight
      if (!busy)
        pfa_ff <= acc_ff[`FCR_ACC_PFE]; // [R2]
      // limitation: a flag changing between setup and access shows on the next read
      if (rd_setup)
        prdata <= nxt_prdata;
      if (start_op)
        cnt_ff <= `FCR_OP_CYCLES;
      else if (busy && cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
      if (finish)
        opc_ff[`FCR_OPC_STA] <= 1'b0;
      if (wr_en && !unmapped)
      begin
        case (ofs)
          `FCR_OFS_ACC:
          begin
            acc_ff[`FCR_ACC_WS_HI:0] <= pwdata[`FCR_ACC_WS_HI:0]; // [R1]
            acc_ff[`FCR_ACC_PFE] <= pwdata[`FCR_ACC_PFE]; // [R2]
          end
          `FCR_OFS_KEY:
          begin
            // one wrong word kills the unlock path until reset
            if (key_dead_ff || unlocked_ff)
              key_dead_ff <= 1'b1; // [R14]
            else if (!key_stage_ff && pwdata == `FCR_KEY1)
              key_stage_ff <= 1'b1; // [R3]
            else if (key_stage_ff && pwdata == `FCR_KEY2)
            begin
              unlocked_ff <= 1'b1; // [R3]
              opc_ff[`FCR_OPC_LOCK] <= 1'b0;
            end
            else
              key_dead_ff <= 1'b1; // [R14]
          end
          `FCR_OFS_OKEY:
          begin
            if (okey_dead_ff || !unlocked_ff)
              okey_dead_ff <= 1'b1; // [R14]
            else if (!okey_stage_ff && pwdata == `FCR_KEY1)
              okey_stage_ff <= 1'b1; // [R4]
            else if (okey_stage_ff && pwdata == `FCR_KEY2)
            begin
              opt_unlocked_ff <= 1'b1; // [R4]
              opc_ff[`FCR_OPC_OBWEN] <= 1'b1;
            end
            else
              okey_dead_ff <= 1'b1; // [R14]
          end
          `FCR_OFS_OPC:
          begin
            if (unlocked_ff)
            begin
              opc_ff <= (pwdata & `FCR_OPC_MASK) | {31'h00000000, 1'b0} // [R10]
                | (opc_ff & 32'h00000040);
              if (!opt_unlocked_ff)
                opc_ff[`FCR_OPC_OBWEN] <= 1'b0; // [R4]
              if (pwdata[`FCR_OPC_STA] && !busy)
                opc_ff[`FCR_OPC_STA] <= 1'b1;
              if (pwdata[`FCR_OPC_LOCK])
              begin
                unlocked_ff <= 1'b0; // [R10]
                opt_unlocked_ff <= 1'b0;
                key_stage_ff <= 1'b0;
                okey_stage_ff <= 1'b0;
                opc_ff[`FCR_OPC_LOCK] <= 1'b1; // [R10]
              end
              else
                opc_ff[`FCR_OPC_LOCK] <= 1'b0;
            end
          end
          `FCR_OFS_ADDR:
            if (unlocked_ff && !busy)
              addr_ff <= pwdata;
          default:
            acc_ff <= acc_ff;
        endcase
      end
    end
  end
  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  assign irq = (opc_ff[`FCR_OPC_ERROR_IRQ_ENABLE] && (sts_ff[`FCR_STS_PERR]
    || sts_ff[`FCR_STS_WPERR])) // [R11]
    || (opc_ff[`FCR_OPC_DONEIE] && sts_ff[`FCR_STS_DONE]); // [R12]
  // ----------------------------------------
  // read wait states
  // ----------------------------------------
  fcr_wait u_wait
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wait_state_count(acc_ff[`FCR_ACC_WS_HI:0]),
    .rd_req(flash_rd_req),
    .rd_ready_ff(flash_rd_ready)
  );
endmodule // fcr_regs
`default_nettype wire

//--- fcr_flash_model.sv
// flash array stand-in: old word contents, protection map, option status
// assumes: one ref_clk domain, words indexed by target_addr[4:1]
`timescale 1ns/10ps
`default_nettype none
module fcr_flash_model
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] target_addr,
  input wire logic op_pulse,
  output logic [15:0] target_old_data,
  output logic target_protected,
  output logic [31:0] option_status,
  output logic [31:0] protect_status
);
  logic [15:0] mem_ff [0:15];
  int k;
  assign target_old_data = mem_ff[target_addr[4:1]];
  // region 0 (addr bits 10:8 zero) is protected, cleared bit means protected
  assign protect_status = 32'hFFFFFFFE;
  assign target_protected = !protect_status[target_addr[10:8]];
  assign option_status = 32'h0000A5F0;
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      for (k = 0; k < 16; k++)
        mem_ff[k] <= 16'hFFFF;
    else if (op_pulse)
      mem_ff[target_addr[4:1]] <= 16'h0000;
  end
endmodule // fcr_flash_model
`default_nettype wire

//--- fcr_regs_assertions.sv
// checker on the ports of the flash register block
// assumes: bound into fcr_regs, clk_en high during checked accesses
`timescale 1ns/10ps
`default_nettype none
`include "fcr_map.vh"
module fcr_regs_chk
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [31:0] option_status,
  input wire logic [31:0] protect_status,
  input wire logic flash_rd_req,
  input wire logic flash_rd_ready,
  input wire logic [2:0] wait_state_count,
  input wire logic op_pulse,
  input wire logic irq
);
  wire logic rd = psel && penable && clk_en && !pwrite;
  wire logic wr = psel && penable && clk_en && pwrite;
  wire logic [7:0] a = paddr[7:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_KEYRD: assert property (rd && a == `FCR_OFS_KEY |-> prdata == 0)
    else $error("key read not zero");
  AST_OKEYRD: assert property (rd && a == `FCR_OFS_OKEY |-> prdata == 0)
    else $error("option key read not zero");
  AST_GAP: assert property (psel && penable && a == `FCR_OFS_GAP |-> pslverr)
    else $error("gap offset accepted");
  AST_OBS: assert property (rd && a == `FCR_OFS_OBS |-> prdata == $past(option_status))
    else $error("option status misread");
  AST_WRP: assert property (rd && a == `FCR_OFS_WRP |-> prdata == $past(protect_status))
    else $error("protect status misread");
  AST_WSREG: assert property (wr && a == 0 |=> wait_state_count == $past(pwdata[2:0]))
    else $error("wait field not taken");
  AST_WS0: assert property (flash_rd_req && clk_en && wait_state_count == 0 |=> flash_rd_ready)
    else $error("zero wait read late");
  AST_WS1: assert property (flash_rd_req && clk_en && wait_state_count == 1 |=> !flash_rd_ready ##1 flash_rd_ready)
    else $error("one wait read off");
  cover property (op_pulse);
  cover property (irq);
  cover property (rd && a == `FCR_OFS_GAP);
endmodule // fcr_regs_chk
bind fcr_regs fcr_regs_chk i_chk (.*);
`default_nettype wire

//--- flash_ctrl_regs_tb_top.sv
// self-checking bench of the flash register block
// assumes: fcr_regs and fcr_flash_model compiled with fcr_map.vh
`timescale 1ns/10ps
`default_nettype none
`include "fcr_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module flash_ctrl_regs_tb_top;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, flash_rd_req = 0, clk_en = 1;
  logic [31:0] paddr = 0, pwdata = 0, prdata, target_addr, option_status, protect_status, rd;
  logic [15:0] target_old_data;
  logic pready, pslverr, target_protected, op_pulse, prefetch_active, irq, flash_rd_ready, slv;
  logic [2:0] wait_state_count;
  logic [31:0] ta [3];
  int err_count = 0, checked = 0, cyc = 0, seed = 61, es = 0, i;
  int pq[$];
  always #5 ref_clk = ~ref_clk;
  fcr_regs i_dut (.*);
  fcr_flash_model i_mem (.*);
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= `FCR_BASE_ADDR | a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    slv = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 0);
    `CHK(rd, e)
  endtask
  // busy shows only for a clean launch; errors land at once
  task automatic op(input logic [31:0] a, input logic [31:0] ie);
    int hit;
    hit = 0;
    // the array keeps one word per index, so a hit is on the word index only
    foreach (pq[k]) if (pq[k][4:1] == a[4:1]) hit = 1;
    es = (hit ? 4 : 0) | ((a[10:8] == 0) ? 16 : 0);
    if (es == 0) es = 1;
    apb(1'b1, `FCR_OFS_OPC, ie);
    apb(1'b1, `FCR_OFS_ADDR, a);
    rchk(`FCR_OFS_STS, es);
    repeat (40) @(posedge ref_clk);
    if (es == 1) es = 32;
    if (es == 32) pq.push_back(a);
    rchk(`FCR_OFS_STS, es);
    `CHK(irq, (es[4] | es[2]) & ie[10] | es[5] & ie[12])
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk(`FCR_OFS_ACC, 0);
    rchk(`FCR_OFS_STS, 0);
    apb(1'b1, `FCR_OFS_OPC, 1);
    rchk(`FCR_OFS_OPC, `FCR_OPC_RST);
    $display("test reset done");
    apb(1'b1, `FCR_OFS_KEY, `FCR_KEY1);
    apb(1'b1, `FCR_OFS_KEY, `FCR_KEY2);
    rchk(`FCR_OFS_KEY, 0);
    rchk(`FCR_OFS_OKEY, 0);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `FCR_OFS_ACC, 32'h10 | i);
      rchk(`FCR_OFS_ACC, 32'h30 | i);
      flash_rd_req <= 1'b1;
      @(posedge ref_clk);
      flash_rd_req <= 1'b0;
      @(posedge ref_clk);
      `CHK(flash_rd_ready, i == 0)
      @(posedge ref_clk);
      `CHK(flash_rd_ready, i == 1)
      `CHK(wait_state_count, i)
      `CHK(prefetch_active, 1'b1)
      @(posedge ref_clk);
    end
    apb(1'b1, `FCR_OFS_ACC, 0);
    rchk(`FCR_OFS_ACC, 0);
    rchk(`FCR_OFS_GAP, 0);
    `CHK(slv, 1'b1)
    rchk(`FCR_OFS_OBS, 32'h0000A5F0);
    rchk(`FCR_OFS_WRP, 32'hFFFFFFFE);
    // frozen clock enable must drop the write
    clk_en <= 1'b0;
    apb(1'b1, `FCR_OFS_ACC, 32'h11);
    clk_en <= 1'b1;
    rchk(`FCR_OFS_ACC, 0);
    $display("test map done");
    ta[0] = 32'h100 | ($random(seed) & 32'h1E);
    ta[1] = ta[0];
    ta[2] = 32'h2;
    for (i = 0; i < 3; i++)
    begin
      op(ta[i], i == 2 ? 32'h1001 : 32'h1401);
      apb(1'b1, `FCR_OFS_STS, 0);
      rchk(`FCR_OFS_STS, es);
      apb(1'b1, `FCR_OFS_STS, 32'h34);
      rchk(`FCR_OFS_STS, 0);
      `CHK(irq, 1'b0)
    end
    $display("test program done");
    apb(1'b1, `FCR_OFS_OPC, 32'h80);
    apb(1'b1, `FCR_OFS_KEY, $random(seed) & 32'hFFFFFFFE);
    apb(1'b1, `FCR_OFS_KEY, `FCR_KEY1);
    apb(1'b1, `FCR_OFS_KEY, `FCR_KEY2);
    apb(1'b1, `FCR_OFS_OPC, 1);
    rchk(`FCR_OFS_OPC, `FCR_OPC_RST);
    $display("test lock done");
    wrap_up;
  end
endmodule // flash_ctrl_regs_tb_top
`default_nettype wire
